// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tmh_regs.vh"

module testbench;
    // Short prescaler keeps the slowest divider affordable in sim
    localparam int PRE = 7;
    logic        CLK, NRST, WR_EN, BIT_WR, BIT_VAL, RD_EN, LSO_CLK;
    logic [15:0] ADDR;
    logic [7:0]  WDATA;
    logic [2:0]  BIT_SEL;
    wire  [7:0]  RDATA, PORT4_OUT, PORT4_OE;
    wire         TIMER_MATCH_IRQ;
    int          err_total, n_tests;

    tmh_timer #(.PRE_W(PRE), .LSO_W(`TMH_LSO_BITS)) u_tmh_timer (
        .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR_EN(WR_EN), .WDATA(WDATA),
        .BIT_WR(BIT_WR), .BIT_SEL(BIT_SEL), .BIT_VAL(BIT_VAL),
        .RD_EN(RD_EN), .RDATA(RDATA), .LSO_CLK(LSO_CLK),
        .TIMER_MATCH_IRQ(TIMER_MATCH_IRQ), .PORT4_OUT(PORT4_OUT),
        .PORT4_OE(PORT4_OE));

    // ************************************************************
    // Clocks
    // ************************************************************
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    // Six system cycles per slow period, edges on falling CLK edges
    initial begin
        LSO_CLK = 1'b0;
        forever #300 LSO_CLK = ~LSO_CLK;
    end

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask

    task automatic bwr(input logic [2:0] s, input logic v);
        @(posedge CLK);
        ADDR    <= `TMH_ADDR_MODE;
        BIT_SEL <= s;
        BIT_VAL <= v;
        BIT_WR  <= 1'b1;
        @(posedge CLK);
        BIT_WR  <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR  <= a;
        RD_EN <= 1'b1;
        @(posedge CLK);
        RD_EN <= 1'b0;
        @(posedge CLK);
        chk("rdata", e, RDATA);
    endtask

    // Counts cycles to the next match and active pin samples on the way
    task automatic meas(input int lim, input logic act, output int n,
                        output int h);
        n = 0;
        h = 0;
        do begin
            @(posedge CLK);
            n++;
            if (PORT4_OUT[`TMH_OUT_PIN] === act) h++;
        end while (TIMER_MATCH_IRQ !== 1'b1 && n < lim);
    endtask

    task automatic stop_check(input logic lev);
        bwr(`TMH_MODE_EN, 1'b0);
        repeat (4) @(posedge CLK);
        chk("idle pin", lev, PORT4_OUT[`TMH_OUT_PIN]);
        chk("idle irq", 1'b0, TIMER_MATCH_IRQ);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_regs;
        rd(`TMH_ADDR_MODE, `TMH_RST_MODE);
        rd(`TMH_ADDR_CYCLE, `TMH_RST_CMP);
        rd(`TMH_ADDR_DUTY, `TMH_RST_CMP);
        rd(`TMH_ADDR_PORT4_DIR, `TMH_RST_PORT4_DIR);
        chk("oe", 8'h00, PORT4_OE);
        rd(16'hFF00, `TMH_RD_UNMAPPED);
        wr(`TMH_ADDR_CYCLE, 8'h5A);
        rd(`TMH_ADDR_CYCLE, 8'h5A);
        wr(`TMH_ADDR_DUTY, 8'hA5);
        rd(`TMH_ADDR_DUTY, 8'hA5);
        bwr(`TMH_MODE_LEV, 1'b1);
        rd(`TMH_ADDR_MODE, 8'h02);
        wr(`TMH_ADDR_MODE, 8'h00);
        rd(`TMH_ADDR_MODE, 8'h00);
        wr(`TMH_ADDR_PORT4_DIR, 8'hFB);
        repeat (2) @(posedge CLK);
        chk("oe", 8'h04, PORT4_OE);
    endtask

    // A period of zero means the code must never produce a match
    task automatic t_interval(input logic [2:0] cks, input logic [7:0] n,
                              input logic lev, input int per);
        int c, h, c2, h2;
        wr(`TMH_ADDR_CYCLE, n);
        wr(`TMH_ADDR_DUTY, 8'h00);
        wr(`TMH_ADDR_MODE, {1'b0, cks, `TMH_MD_INTERVAL, lev, 1'b1});
        bwr(`TMH_MODE_EN, 1'b1);
        if (per == 0) begin
            meas(300, 1'b1, c, h);
            chk("no match", 16'h012C, 16'(c));
        end else begin
            meas(per + per / (n + 1) + 6, 1'b1, c, h);
            chk("first match", 1'b1, TIMER_MATCH_IRQ);
            meas(per + 2, 1'b1, c, h);
            meas(per + 2, 1'b1, c2, h2);
            chk("period", 16'(per), 16'(c));
            chk("period", 16'(per), 16'(c2));
            chk("high", 16'(per), 16'(h + h2));
        end
        stop_check(lev);
    endtask

    task automatic t_pwm(input logic [7:0] n, input logic [7:0] m);
        int c, h;
        wr(`TMH_ADDR_CYCLE, n);
        wr(`TMH_ADDR_MODE, {4'h0, `TMH_MD_PWM, 2'b01});
        wr(`TMH_ADDR_DUTY, m);
        bwr(`TMH_MODE_EN, 1'b1);
        meas(n + 8, 1'b1, c, h);
        chk("early active", 16'h0000, 16'(h));
        meas(n + 3, 1'b1, c, h);
        chk("pwm period", n + 16'h0001, 16'(c));
        chk("pwm width", m + 16'h0001, 16'(h));
        // Written mid-period, lands before the old duty match
        wr(`TMH_ADDR_DUTY, m + 8'h01);
        meas(n + 3, 1'b1, c, h);
        meas(n + 3, 1'b1, c, h);
        chk("new width", m + 16'h0002, 16'(h));
        // Write lands on the old duty match, so one more old-width period
        repeat (m - 1) @(posedge CLK);
        wr(`TMH_ADDR_DUTY, m + 8'h02);
        meas(n + 3, 1'b1, c, h);
        meas(n + 3, 1'b1, c, h);
        chk("late width", m + 16'h0002, 16'(h));
        stop_check(1'b0);
    endtask

    // ************************************************************
    // Sequencing and verdict
    // ************************************************************
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #(100 * 40000);
        err_total++;
        conclude;
    end

    initial begin
        err_total = 0;
        n_tests = 0;
        NRST = 1'b0;
        WR_EN = 1'b0;
        BIT_WR = 1'b0;
        RD_EN = 1'b0;
        BIT_VAL = 1'b0;
        BIT_SEL = 3'h0;
        ADDR = 16'h0000;
        WDATA = 8'h00;
        repeat (12) @(posedge CLK);
        NRST <= 1'b1;
        t_regs;
        t_interval(`TMH_CKS_DIV1, 8'h03, 1'b0, 4);
        t_interval(`TMH_CKS_DIV1, 8'hFF, 1'b0, 256);
        t_interval(`TMH_CKS_DIV4, 8'h03, 1'b1, 16);
        t_interval(`TMH_CKS_DIV16, 8'h01, 1'b0, 32);
        t_interval(`TMH_CKS_DIV64, 8'h01, 1'b0, 128);
        t_interval(`TMH_CKS_DIV4096, 8'h01, 1'b0, 2 << PRE);
        t_interval(`TMH_CKS_LSO128, 8'h01, 1'b0, 1536);
        t_interval(3'h6, 8'h01, 1'b0, 0);
        t_pwm(8'h09, 8'h04);
        conclude;
    end
endmodule
`default_nettype wire

// [bench/tmh_timer_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tmh_regs.vh"

module tmh_timer_checker #(
    parameter PRE_W = `TMH_DIV4096_BITS,
    parameter LSO_W = `TMH_LSO_BITS
) (
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic [15:0] ADDR,
    input wire logic        WR_EN,
    input wire logic [7:0]  WDATA,
    input wire logic        BIT_WR,
    input wire logic [2:0]  BIT_SEL,
    input wire logic        BIT_VAL,
    input wire logic        RD_EN,
    input wire logic [7:0]  RDATA,
    input wire logic        LSO_CLK,
    input wire logic        TIMER_MATCH_IRQ,
    input wire logic [7:0]  PORT4_OUT,
    input wire logic [7:0]  PORT4_OE
);
    // ************************************************************
    // Shadow of software-visible state
    // ************************************************************
    logic [7:0]  mode_m;
    logic [7:0]  cyc_m;
    logic [15:0] gap;
    logic        seen;
    wire         en_m = mode_m[`TMH_MODE_EN];
    wire  [1:0]  md_m = mode_m[`TMH_MODE_MD_MSB:`TMH_MODE_MD_LSB];

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    // Gap only trusted between two matches of one enabled run
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_m <= 8'h00;
            cyc_m  <= 8'h00;
            gap    <= 16'h0000;
            seen   <= 1'b0;
        end else begin
            if (WR_EN && ADDR == `TMH_ADDR_MODE)
                mode_m <= WDATA;
            else if (BIT_WR && ADDR == `TMH_ADDR_MODE)
                mode_m[BIT_SEL] <= BIT_VAL;
            if (WR_EN && ADDR == `TMH_ADDR_CYCLE)
                cyc_m <= WDATA;
            gap  <= TIMER_MATCH_IRQ ? 16'h0001 : gap + 16'h0001;
            seen <= en_m && (seen || TIMER_MATCH_IRQ);
        end
    end

    // ************************************************************
    // Sequences
    // ************************************************************
    sequence s_idle;
        (!en_m && $stable(mode_m))[*4];
    endsequence
    sequence s_int_match;
        TIMER_MATCH_IRQ && en_m && md_m == `TMH_MD_INTERVAL && mode_m[0];
    endsequence
    sequence s_pwm_match;
        TIMER_MATCH_IRQ && en_m && md_m == `TMH_MD_PWM && mode_m[0];
    endsequence

    // ************************************************************
    // Properties
    // ************************************************************
    property p_irq_pulse;
        TIMER_MATCH_IRQ && (cyc_m != 8'h00 || mode_m[6:4] != 3'h0)
            |=> !TIMER_MATCH_IRQ;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt pulse longer than one cycle");

    property p_oe_dir;
        logic [7:0] d;
        (WR_EN && ADDR == `TMH_ADDR_PORT4_DIR, d = WDATA)
            |-> ##2 PORT4_OE == ~d;
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("pin enables do not follow direction write");

    property p_mode_rd;
        RD_EN && ADDR == `TMH_ADDR_MODE |=> RDATA == $past(mode_m);
    endproperty
    a_mode_rd: assert property (p_mode_rd)
        else $error("mode register read back wrong");

    property p_cyc_rd;
        RD_EN && ADDR == `TMH_ADDR_CYCLE |=> RDATA == $past(cyc_m);
    endproperty
    a_cyc_rd: assert property (p_cyc_rd)
        else $error("cycle compare read back wrong");

    property p_idle_irq;
        s_idle |-> !TIMER_MATCH_IRQ;
    endproperty
    a_idle_irq: assert property (p_idle_irq)
        else $error("interrupt while counting stopped");

    property p_idle_pin;
        s_idle |-> PORT4_OUT[`TMH_OUT_PIN] == mode_m[`TMH_MODE_LEV];
    endproperty
    a_idle_pin: assert property (p_idle_pin)
        else $error("stopped output not at default level");

    property p_period;
        TIMER_MATCH_IRQ && seen && en_m && mode_m[6:4] == 3'h0
            |-> gap == {8'h00, cyc_m} + 16'h0001;
    endproperty
    a_period: assert property (p_period)
        else $error("match interval not compare plus one");

    property p_int_toggle;
        s_int_match |=> PORT4_OUT[`TMH_OUT_PIN] !=
            $past(PORT4_OUT[`TMH_OUT_PIN]);
    endproperty
    a_int_toggle: assert property (p_int_toggle)
        else $error("output did not invert on interval match");

    property p_pwm_act;
        s_pwm_match |=> PORT4_OUT[`TMH_OUT_PIN] == ~mode_m[`TMH_MODE_LEV];
    endproperty
    a_pwm_act: assert property (p_pwm_act)
        else $error("output not active after cycle match");
endmodule

bind tmh_timer tmh_timer_checker #(
    .PRE_W(PRE_W),
    .LSO_W(LSO_W)
) u_tmh_timer_checker (
    .CLK(CLK), .NRST(NRST), .ADDR(ADDR), .WR_EN(WR_EN), .WDATA(WDATA),
    .BIT_WR(BIT_WR), .BIT_SEL(BIT_SEL), .BIT_VAL(BIT_VAL),
    .RD_EN(RD_EN), .RDATA(RDATA), .LSO_CLK(LSO_CLK),
    .TIMER_MATCH_IRQ(TIMER_MATCH_IRQ), .PORT4_OUT(PORT4_OUT),
    .PORT4_OE(PORT4_OE)
);
`default_nettype wire

// [hw/tmh_prescaler.v]
`timescale 1ns/1ps
`default_nettype none
`include "tmh_regs.vh"

module tmh_prescaler #(
    parameter PRE_W = `TMH_DIV4096_BITS,
    parameter LSO_W = `TMH_LSO_BITS
) (
    input  wire       clk,
    input  wire       nrst,
    input  wire       run,
    input  wire [2:0] sel,
    input  wire       lso_in,
    output reg        tick
);

    reg  [PRE_W-1:0] pre_reg;
    reg  [LSO_W-1:0] lso_cnt_reg;
    reg              lso_q_reg;
    wire             lso_rise;

    assign lso_rise = lso_in & ~lso_q_reg;

    // ************************************************************
    // Dividers restart while stopped, so the first tick comes
    // at most one count clock after enable
    // ************************************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_reg     <= {PRE_W{1'b0}};
            lso_cnt_reg <= {LSO_W{1'b0}};
            lso_q_reg   <= 1'b0;
        end else begin
            lso_q_reg <= lso_in;
            if (!run) begin
                pre_reg     <= {PRE_W{1'b0}};
                lso_cnt_reg <= {LSO_W{1'b0}};
            end else begin
                pre_reg <= pre_reg + {{(PRE_W-1){1'b0}}, 1'b1};
                if (lso_rise) begin
                    lso_cnt_reg <= lso_cnt_reg + {{(LSO_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    always @* begin
        case (sel)
            `TMH_CKS_DIV1:    tick = run;
            `TMH_CKS_DIV4:    tick = run & (&pre_reg[`TMH_DIV4_BITS-1:0]);
            `TMH_CKS_DIV16:   tick = run & (&pre_reg[`TMH_DIV16_BITS-1:0]);
            `TMH_CKS_DIV64:   tick = run & (&pre_reg[`TMH_DIV64_BITS-1:0]);
            `TMH_CKS_DIV4096: tick = run & (&pre_reg);
            `TMH_CKS_LSO128:  tick = run & lso_rise & (&lso_cnt_reg);
            // Prohibited codes never count
            default:          tick = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// [hw/tmh_timer.v]
// Overview of operation
// - Compare registers are 8-bit, reset to zero
// - Duty write while counting in PWM waits for old match
// - Write colliding with match waits one more match
// - Enable bit starts counting; clearing zeroes counter
// - Clock select picks one of six count clocks
// - Mode field selects interval or PWM
// - Output level bit sets default pin level
// - Interval mode with output enable gives square wave
// - Interval match raises interrupt and clears counter
// - Interval mode ignores duty compare completely
// - Interval interrupt repeats every compare plus one
// - Counting starts within one count clock
// - Interval match inverts output with clear and interrupt
// - Disable forces interrupt and output inactive
// - Direction register resets to ones; zero means output
// - Mode register resets zero, takes bit and byte writes
// - PWM cycle match clears, interrupts, activates, targets duty
// - PWM duty match deactivates, targets cycle, no clear
// - PWM masks first count clock, output stays inactive
`timescale 1ns/1ps
`default_nettype none
`include "tmh_regs.vh"

module tmh_timer #(
    parameter PRE_W = `TMH_DIV4096_BITS,
    parameter LSO_W = `TMH_LSO_BITS
) (
    input  wire        CLK,
    input  wire        NRST,
    input  wire [15:0] ADDR,
    input  wire        WR_EN,
    input  wire [7:0]  WDATA,
    input  wire        BIT_WR,
    input  wire [2:0]  BIT_SEL,
    input  wire        BIT_VAL,
    input  wire        RD_EN,
    output reg  [7:0]  RDATA,
    input  wire        LSO_CLK,
    output reg         TIMER_MATCH_IRQ,
    output reg  [7:0]  PORT4_OUT,
    output reg  [7:0]  PORT4_OE
);

    // ************************************************************
    // Counter states
    // ************************************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CYC  = 3'b010;
    localparam [2:0] ST_DUTY = 3'b100;

    // ************************************************************
    // Helpers
    // ************************************************************
    function [7:0] bit_merge;
        input [7:0] old;
        input [2:0] sel;
        input       val;
        begin
            bit_merge = old;
            bit_merge[sel] = val;
        end
    endfunction

    function [7:0] inc8;
        input [7:0] v;
        begin
            inc8 = v + 8'h01;
        end
    endfunction

    // ************************************************************
    // Storage
    // ************************************************************
    reg  [7:0] mode_reg;
    reg  [7:0] mode_next;
    reg  [7:0] cycle_reg;
    reg  [7:0] cycle_next;
    reg  [7:0] duty_wr_reg;
    reg  [7:0] duty_wr_next;
    reg  [7:0] duty_act_reg;
    reg  [7:0] duty_act_next;
    reg        pend_reg;
    reg        pend_next;
    reg  [7:0] dir_reg;
    reg  [7:0] dir_next;
    reg  [7:0] latch_reg;
    reg  [7:0] latch_next;
    reg  [7:0] cnt_reg;
    reg  [7:0] cnt_next;
    reg  [2:0] state_reg;
    reg  [2:0] state_next;
    reg        skip_reg;
    reg        skip_next;
    reg        active_reg;
    reg        active_next;
    reg        irq_next;
    reg  [7:0] rdata_next;
    reg        pin_level;
    reg  [7:0] port_out_next;

    wire       cnt_en;
    wire [2:0] cks;
    wire [1:0] op_mode;
    wire       is_pwm;
    wire       out_default_level;
    wire       out_enable;
    wire       tick;
    wire       duty_write;
    wire       byte_hit_mode;

    assign cnt_en            = mode_reg[`TMH_MODE_EN];
    assign cks               = mode_reg[`TMH_MODE_CKS_MSB:`TMH_MODE_CKS_LSB];
    assign op_mode           = mode_reg[`TMH_MODE_MD_MSB:`TMH_MODE_MD_LSB];
    assign is_pwm            = (op_mode == `TMH_MD_PWM);
    assign out_default_level = mode_reg[`TMH_MODE_LEV];
    assign out_enable        = mode_reg[`TMH_MODE_OEN];
    assign duty_write        = WR_EN && (ADDR == `TMH_ADDR_DUTY);
    assign byte_hit_mode     = WR_EN && (ADDR == `TMH_ADDR_MODE);

    // ************************************************************
    // Count clock
    // ************************************************************
    tmh_prescaler #(
        .PRE_W (PRE_W),
        .LSO_W (LSO_W)
    ) u_prescaler (
        .clk    (CLK),
        .nrst   (NRST),
        .run    (cnt_en),
        .sel    (cks),
        .lso_in (LSO_CLK),
        .tick   (tick)
    );

    // ************************************************************
    // Register writes
    // ************************************************************
    always @* begin
        mode_next  = mode_reg;
        cycle_next = cycle_reg;
        dir_next   = dir_reg;
        latch_next = latch_reg;
        if (byte_hit_mode) begin
            mode_next = WDATA;
        end else if (BIT_WR && (ADDR == `TMH_ADDR_MODE)) begin
            mode_next = bit_merge(mode_reg, BIT_SEL, BIT_VAL);
        end else if (WR_EN && (ADDR == `TMH_ADDR_CYCLE)) begin
            cycle_next = WDATA;
        end else if (WR_EN && (ADDR == `TMH_ADDR_PORT4_DIR)) begin
            dir_next = WDATA;
        end else if (BIT_WR && (ADDR == `TMH_ADDR_PORT4_DIR)) begin
            dir_next = bit_merge(dir_reg, BIT_SEL, BIT_VAL);
        end else if (WR_EN && (ADDR == `TMH_ADDR_PORT4_LATCH)) begin
            latch_next = WDATA;
        end else if (BIT_WR && (ADDR == `TMH_ADDR_PORT4_LATCH)) begin
            latch_next = bit_merge(latch_reg, BIT_SEL, BIT_VAL);
        end
    end

    // ************************************************************
    // Counter, compare target and output state
    // ************************************************************
    always @* begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        skip_next     = skip_reg;
        active_next   = active_reg;
        irq_next      = 1'b0;
        duty_wr_next  = duty_wr_reg;
        duty_act_next = duty_act_reg;
        pend_next     = pend_reg;

        // Duty writes while idle or in interval mode load at once
        if (duty_write) begin
            duty_wr_next = WDATA;
            if (!cnt_en || !is_pwm) begin
                duty_act_next = WDATA;
                pend_next     = 1'b0;
            end else begin
                pend_next = 1'b1;
            end
        end

        case (state_reg)
            ST_IDLE: begin
                cnt_next    = 8'h00;
                active_next = 1'b0;
                if (cnt_en) begin
                    state_next = ST_CYC;
                    skip_next  = is_pwm;
                end
            end
            ST_CYC: begin
                if (!cnt_en) begin
                    state_next  = ST_IDLE;
                    cnt_next    = 8'h00;
                    active_next = 1'b0;
                    if (pend_reg && !duty_write) begin
                        duty_act_next = duty_wr_reg;
                        pend_next     = 1'b0;
                    end
                end else if (tick) begin
                    if (skip_reg) begin
                        skip_next = 1'b0;
                    end else if (cnt_reg == cycle_reg) begin
                        cnt_next = 8'h00;
                        irq_next = 1'b1;
                        if (is_pwm) begin
                            active_next = 1'b1;
                            state_next  = ST_DUTY;
                        end else begin
                            active_next = ~active_reg;
                        end
                    end else begin
                        cnt_next = inc8(cnt_reg);
                    end
                end
            end
            ST_DUTY: begin
                if (!cnt_en) begin
                    state_next  = ST_IDLE;
                    cnt_next    = 8'h00;
                    active_next = 1'b0;
                    if (pend_reg && !duty_write) begin
                        duty_act_next = duty_wr_reg;
                        pend_next     = 1'b0;
                    end
                end else if (tick) begin
                    cnt_next = inc8(cnt_reg);
                    if (cnt_reg == duty_act_reg) begin
                        active_next = 1'b0;
                        state_next  = ST_CYC;
                        // A write in this very cycle waits for next match
                        if (pend_reg && !duty_write) begin
                            duty_act_next = duty_wr_reg;
                            pend_next     = 1'b0;
                        end
                    end
                end
            end
            default: begin
                state_next  = ST_IDLE;
                cnt_next    = 8'h00;
                active_next = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Pin level and read data
    // ************************************************************
    always @* begin
        // Duty compare never reaches the pin in interval mode
        if (out_enable) begin
            pin_level = active_reg ^ out_default_level;
        end else begin
            pin_level = out_default_level;
        end
        port_out_next = latch_reg;
        // Latch ORs in, so it must be zero for the timer to show
        port_out_next[`TMH_OUT_PIN] = latch_reg[`TMH_OUT_PIN] | pin_level;
    end

    always @* begin
        rdata_next = RDATA;
        if (RD_EN) begin
            if (ADDR == `TMH_ADDR_MODE) begin
                rdata_next = mode_reg;
            end else if (ADDR == `TMH_ADDR_CYCLE) begin
                rdata_next = cycle_reg;
            end else if (ADDR == `TMH_ADDR_DUTY) begin
                rdata_next = duty_wr_reg;
            end else if (ADDR == `TMH_ADDR_PORT4_DIR) begin
                rdata_next = dir_reg;
            end else if (ADDR == `TMH_ADDR_PORT4_LATCH) begin
                rdata_next = latch_reg;
            end else begin
                rdata_next = `TMH_RD_UNMAPPED;
            end
        end
    end

    // ************************************************************
    // Flops
    // ************************************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            mode_reg        <= `TMH_RST_MODE;
            cycle_reg       <= `TMH_RST_CMP;
            duty_wr_reg     <= `TMH_RST_CMP;
            duty_act_reg    <= `TMH_RST_CMP;
            pend_reg        <= 1'b0;
            dir_reg         <= `TMH_RST_PORT4_DIR;
            latch_reg       <= `TMH_RST_PORT4_LATCH;
            cnt_reg         <= 8'h00;
            state_reg       <= ST_IDLE;
            skip_reg        <= 1'b0;
            active_reg      <= 1'b0;
            TIMER_MATCH_IRQ <= 1'b0;
            RDATA           <= `TMH_RD_UNMAPPED;
            PORT4_OUT       <= `TMH_RST_PORT4_LATCH;
            PORT4_OE        <= ~`TMH_RST_PORT4_DIR;
        end else begin
            mode_reg        <= mode_next;
            cycle_reg       <= cycle_next;
            duty_wr_reg     <= duty_wr_next;
            duty_act_reg    <= duty_act_next;
            pend_reg        <= pend_next;
            dir_reg         <= dir_next;
            latch_reg       <= latch_next;
            cnt_reg         <= cnt_next;
            state_reg       <= state_next;
            skip_reg        <= skip_next;
            active_reg      <= active_next;
            TIMER_MATCH_IRQ <= irq_next;
            RDATA           <= rdata_next;
            PORT4_OUT       <= port_out_next;
            PORT4_OE        <= ~dir_reg;
        end
    end

endmodule

`default_nettype wire

// [pkg/tmh_regs.vh]
`ifndef TMH_REGS_VH
`define TMH_REGS_VH

// ************************************************************
// Register addresses
// ************************************************************
`define TMH_ADDR_PORT4_DIR   16'hFF24
`define TMH_ADDR_MODE        16'hFF70
`define TMH_ADDR_CYCLE       16'hFF72
`define TMH_ADDR_DUTY        16'hFF73
`define TMH_ADDR_PORT4_LATCH 16'hFF04

// ************************************************************
// Reset values
// ************************************************************
`define TMH_RST_MODE         8'h00
`define TMH_RST_CMP          8'h00
`define TMH_RST_PORT4_DIR    8'hFF
`define TMH_RST_PORT4_LATCH  8'h00
`define TMH_RD_UNMAPPED      8'h00

// ************************************************************
// Mode register fields
// ************************************************************
`define TMH_MODE_EN          7
`define TMH_MODE_CKS_MSB     6
`define TMH_MODE_CKS_LSB     4
`define TMH_MODE_MD_MSB      3
`define TMH_MODE_MD_LSB      2
`define TMH_MODE_LEV         1
`define TMH_MODE_OEN         0

// ************************************************************
// Field encodings
// ************************************************************
`define TMH_CKS_DIV1         3'h0
`define TMH_CKS_DIV4         3'h1
`define TMH_CKS_DIV16        3'h2
`define TMH_CKS_DIV64        3'h3
`define TMH_CKS_DIV4096      3'h4
`define TMH_CKS_LSO128       3'h5
`define TMH_MD_INTERVAL      2'h0
`define TMH_MD_PWM           2'h2

// ************************************************************
// Divider widths (log2 of each ratio) and pin position
// ************************************************************
`define TMH_DIV4_BITS        2
`define TMH_DIV16_BITS       4
`define TMH_DIV64_BITS       6
`define TMH_DIV4096_BITS     12
`define TMH_LSO_BITS         7
`define TMH_OUT_PIN          2

`endif
